// ### hdl/hkscn_pkg.sv
// Constants, register map and state types of the hex keypad scanner.
// Assumes a 100 MHz hclk; one controller scan cycle is a fixed hclk count.
package hkscn_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned SCAN_PERIOD_NS = 10000;
  localparam int unsigned SCAN_TICKS_DEF = SCAN_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned CONFIRM_DEF    = 2;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [5:0] ADDR_CTRL     = 6'h00;
  localparam logic [5:0] ADDR_DATA_LO  = 6'h04;
  localparam logic [5:0] ADDR_DATA_HI  = 6'h08;
  localparam logic [5:0] ADDR_KEYS     = 6'h0c;
  localparam logic [5:0] ADDR_STATUS   = 6'h10;
  localparam logic [5:0] ADDR_IRQ_STAT = 6'h14;
  localparam logic [5:0] ADDR_IRQ_CLR  = 6'h18;
  localparam logic [5:0] ADDR_IRQ_EN   = 6'h1c;
  localparam logic [5:0] ADDR_CFG      = 6'h20;

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_EN_BIT   = 0;
  localparam int CTRL_CLR_BIT  = 1;
  localparam logic [1:0] CTRL_RST = 2'h1;
  localparam int CFG_AREA_D_LSB  = 0;
  localparam int CFG_AREA_D2_LSB = 4;
  localparam int CFG_IND_BIT     = 8;
  localparam int CFG_ADDR_LSB    = 16;
  localparam logic [31:0] CFG_RST = 32'h0;
  localparam logic [15:0] AREA_LAST_BASE = 16'h6141;
  localparam int ST_ACTIVE_BIT = 0;
  localparam int ST_ERR_BIT    = 1;
  localparam int KEYDOWN_BIT   = 4;
  localparam int IRQ_KEY_BIT   = 0;
  localparam int IRQ_REL_BIT   = 1;
  localparam int IRQ_ERR_BIT   = 2;
  localparam logic [2:0] IRQ_RST = 3'h0;

  // ----------------------------------------------------------------
  // Scanner states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_SCAN    = 3'b001,
    ST_CONFIRM = 3'b010,
    ST_HELD    = 3'b100
  } hkscn_state_e;

endpackage

// ### hdl/hkscn_regbus_if.sv
// Register access path between the bus front end and the scanner core.
// Assumes both ends run on hclk.
`timescale 1ns/1ps
`default_nettype none
interface hkscn_regbus_if;
  logic        wr_en;
  logic [5:0]  wr_addr;
  logic [31:0] wdata;
  logic [5:0]  rd_addr;
  logic [31:0] rd_data;

  modport bus  (output wr_en, output wr_addr, output wdata, output rd_addr, input rd_data);
  modport regs (input wr_en, input wr_addr, input wdata, input rd_addr, output rd_data);
endinterface
`default_nettype wire

// ### hdl/hkscn_ahb_slave.sv
// AHB-Lite slave front end of the keypad scanner, zero wait states.
// Assumes single word transfers; the register file answers reads at once.
`timescale 1ns/1ps
`default_nettype none
module hkscn_ahb_slave
  import hkscn_pkg::*;
(
  input  wire logic          hclk,
  input  wire logic          hresetn,
  input  wire logic          hsel,
  input  wire logic [31:0]   hkscn_addr,
  input  wire logic [1:0]    htrans,
  input  wire logic          hwrite,
  input  wire logic          hready,
  input  wire logic [31:0]   hwdata,
  output logic               hreadyout,
  output logic [31:0]        hrdata,
  output logic               hresp,
  hkscn_regbus_if.bus        rb
);

  logic        aphase;
  logic        wpend_r,  wpend_nxt;
  logic [5:0]  waddr_r,  waddr_nxt;
  logic [31:0] rdata_r,  rdata_nxt;

  // ----------------------------------------------------------------
  // Address phase capture
  // ----------------------------------------------------------------
  assign aphase = hsel & htrans[1] & hready;

  // Write commits at the end of its data phase; read data registered
  always_comb
  begin
    wpend_nxt = aphase & hwrite;
    waddr_nxt = aphase ? hkscn_addr[5:0] : waddr_r;
    rdata_nxt = (aphase & ~hwrite) ? rb.rd_data : 32'h0;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wpend_r <= 1'b0;
      waddr_r <= 6'h0;
      rdata_r <= 32'h0;
    end
    else
    begin
      wpend_r <= wpend_nxt;
      waddr_r <= waddr_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Register file side
  assign rb.wr_en   = wpend_r;
  assign rb.wr_addr = waddr_r;
  assign rb.wdata   = hwdata;
  assign rb.rd_addr = hkscn_addr[5:0];

  // Always ready, always OKAY
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  assign hrdata = rdata_r;

endmodule
`default_nettype wire

// ### hdl/hkscn_top.sv
// Hex keypad matrix scanner: drives four select lines, reads four sense
// lines, keeps an eight digit key register, a pressed-key word and flags.
// Assumes a passive 4 x 4 switch matrix; sense inputs are asynchronous.
//
// Notes on behaviour
// - Disabled: no selects, registers unchanged.
// - Eight hex digits shift up per key.
// - New key value enters lowest digit.
// - Key word bit set while key held.
// - Select word bit 4 high while pressed.
// - Other keys ignored while one held.
// - Select lines in turn; 3-7 scan cycles.
// - Four sense inputs, five select outputs.
// - Active flag high while enabled, also on error.
// - Error on area mismatch or bad indirect address.
// - Scanning starts one scan period after start.
`timescale 1ns/1ps
`default_nettype none
module hkscn_top
  import hkscn_pkg::*;
#(
  parameter int unsigned SCAN_TICKS = hkscn_pkg::SCAN_TICKS_DEF,
  parameter int unsigned CONFIRM    = hkscn_pkg::CONFIRM_DEF
)
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic [3:0]  sense_input_word,
  output logic [4:0]       select_output_word,
  output logic             irq
);

  localparam int TW = $clog2(SCAN_TICKS + 1);
  localparam int CW = $clog2(CONFIRM + 1);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  function automatic logic [3:0] onehot4(input logic [1:0] idx);
    onehot4 = 4'h1 << idx;
  endfunction

  function automatic logic [1:0] lowest4(input logic [3:0] v);
    lowest4 = v[0] ? 2'd0 : v[1] ? 2'd1 : v[2] ? 2'd2 : 2'd3;
  endfunction

  function automatic logic bcd_ok(input logic [15:0] v);
    bcd_ok = (v[3:0] < 4'ha) && (v[7:4] < 4'ha) && (v[11:8] < 4'ha) && (v[15:12] < 4'ha);
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  hkscn_regbus_if rb ();

  logic [3:0]   sense_m_r, sense_s_r;
  logic [1:0]   ctrl_r, ctrl_nxt;
  logic [31:0]  cfg_r, cfg_nxt;
  logic [2:0]   ien_r, ien_nxt;
  logic [2:0]   ist_r, ist_nxt;
  logic         irq_nxt;
  logic         dclr;
  logic [2:0]   iclr;
  logic [TW-1:0] tcnt_r, tcnt_nxt;
  logic         tick;
  logic         run, err, exec;
  hkscn_state_e st_r, st_nxt;
  logic [1:0]   col_r, col_nxt;
  logic [3:0]   key_r, key_nxt;
  logic [CW-1:0] cfm_r, cfm_nxt;
  logic [31:0]  digits_r, digits_nxt;
  logic [15:0]  keys_r, keys_nxt;
  logic [4:0]   sel_r, sel_nxt;
  logic         ev_key, ev_rel;
  logic [1:0]   next_col;
  logic         row_hit;

  // ----------------------------------------------------------------
  // Bus front end
  // ----------------------------------------------------------------
  hkscn_ahb_slave u_ahb (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .hsel       (hsel),
    .hkscn_addr (haddr),
    .htrans     (htrans),
    .hwrite     (hwrite),
    .hready     (hready),
    .hwdata     (hwdata),
    .hreadyout  (hreadyout),
    .hrdata     (hrdata),
    .hresp      (hresp),
    .rb         (rb.bus)
  );

  // ----------------------------------------------------------------
  // Sense input synchroniser
  // ----------------------------------------------------------------
  // Two flops before any logic looks at the keypad lines
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sense_m_r <= 4'h0;
      sense_s_r <= 4'h0;
    end
    else
    begin
      sense_m_r <= sense_input_word;
      sense_s_r <= sense_m_r;
    end
  end

  // ----------------------------------------------------------------
  // Control registers and interrupt status
  // ----------------------------------------------------------------
  // Software writes; hardware events win over a clear in the same cycle
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    cfg_nxt  = cfg_r;
    ien_nxt  = ien_r;
    dclr     = 1'b0;
    iclr     = 3'h0;
    if (rb.wr_en)
    begin
      case (rb.wr_addr)
        ADDR_CTRL:
        begin
          ctrl_nxt[CTRL_EN_BIT] = rb.wdata[CTRL_EN_BIT];
          dclr                  = rb.wdata[CTRL_CLR_BIT];
        end
        ADDR_CFG:     cfg_nxt = rb.wdata;
        ADDR_IRQ_EN:  ien_nxt = rb.wdata[2:0];
        ADDR_IRQ_CLR: iclr    = rb.wdata[2:0];
        default:      ctrl_nxt = ctrl_r;
      endcase
    end
    ist_nxt = (ist_r & ~iclr)
            | {exec ? 1'b0 : (tick & run & err), ev_rel, ev_key};
    irq_nxt = |(ist_r & ien_r);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_r <= CTRL_RST;
      cfg_r  <= CFG_RST;
      ien_r  <= IRQ_RST;
      ist_r  <= IRQ_RST;
      irq    <= 1'b0;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      cfg_r  <= cfg_nxt;
      ien_r  <= ien_nxt;
      ist_r  <= ist_nxt;
      irq    <= irq_nxt;
    end
  end

  // Operand checks: D and D+2 areas, indirect address BCD and bounds
  assign err = (cfg_r[CFG_AREA_D_LSB +: 4] != cfg_r[CFG_AREA_D2_LSB +: 4])
             | (cfg_r[CFG_IND_BIT] & (~bcd_ok(cfg_r[CFG_ADDR_LSB +: 16])
             | (cfg_r[CFG_ADDR_LSB +: 16] > AREA_LAST_BASE)));
  assign run  = ctrl_r[CTRL_EN_BIT];
  assign exec = run & ~err;

  // ----------------------------------------------------------------
  // Scan cycle timer
  // ----------------------------------------------------------------
  // Restarts on enable so the first execution follows one scan period
  always_comb
  begin
    tick = (tcnt_r == TW'(SCAN_TICKS - 1));
    if (!run || tick)
    begin
      tcnt_nxt = '0;
    end
    else
    begin
      tcnt_nxt = tcnt_r + TW'(1);
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tcnt_r <= '0;
    end
    else
    begin
      tcnt_r <= tcnt_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Matrix scanner
  // ----------------------------------------------------------------
  // One execution per scan tick; sense reflects last tick's select
  always_comb
  begin
    st_nxt     = st_r;
    col_nxt    = col_r;
    key_nxt    = key_r;
    cfm_nxt    = cfm_r;
    digits_nxt = dclr ? 32'h0 : digits_r;
    keys_nxt   = keys_r;
    sel_nxt    = sel_r;
    ev_key     = 1'b0;
    ev_rel     = 1'b0;
    next_col   = (sel_r[3:0] == 4'h0) ? col_r : col_r + 2'd1;
    row_hit    = sense_s_r[key_r[3:2]];
    if (!run)
    begin
      // Idle: all selects off, digits and key word kept
      st_nxt  = ST_SCAN;
      col_nxt = 2'd0;
      cfm_nxt = '0;
      sel_nxt = 5'h0;
    end
    else if (tick && exec)
    begin
      case (st_r)
        ST_SCAN:
        begin
          // No key held here; drops a word left over from a stop mid-press
          keys_nxt = 16'h0;
          if ((sel_r[3:0] == onehot4(col_r)) && (sense_s_r != 4'h0))
          begin
            // Candidate key: row from sense, column from select
            key_nxt = {lowest4(sense_s_r), col_r};
            cfm_nxt = '0;
            st_nxt  = ST_CONFIRM;
          end
          else
          begin
            col_nxt = next_col;
            sel_nxt = {1'b0, onehot4(next_col)};
          end
        end
        ST_CONFIRM:
        begin
          if (!row_hit)
          begin
            col_nxt = col_r + 2'd1;
            sel_nxt = {1'b0, onehot4(col_r + 2'd1)};
            st_nxt  = ST_SCAN;
          end
          else if (cfm_r == CW'(CONFIRM - 1))
          begin
            // Accept: shift digits up, new digit at the bottom
            digits_nxt = {digits_nxt[27:0], key_nxt};
            keys_nxt   = 16'h1 << key_r;
            sel_nxt[KEYDOWN_BIT] = 1'b1;
            ev_key     = 1'b1;
            st_nxt     = ST_HELD;
          end
          else
          begin
            cfm_nxt = cfm_r + CW'(1);
          end
        end
        ST_HELD:
        begin
          // Only the held key's row and column are watched
          if (!row_hit)
          begin
            keys_nxt = 16'h0;
            sel_nxt  = {1'b0, onehot4(col_r + 2'd1)};
            col_nxt  = col_r + 2'd1;
            ev_rel   = 1'b1;
            st_nxt   = ST_SCAN;
          end
        end
        default:
        begin
          st_nxt  = ST_SCAN;
          sel_nxt = 5'h0;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_r     <= ST_SCAN;
      col_r    <= 2'd0;
      key_r    <= 4'h0;
      cfm_r    <= '0;
      digits_r <= 32'h0;
      keys_r   <= 16'h0;
      sel_r    <= 5'h0;
    end
    else
    begin
      st_r     <= st_nxt;
      col_r    <= col_nxt;
      key_r    <= key_nxt;
      cfm_r    <= cfm_nxt;
      digits_r <= digits_nxt;
      keys_r   <= keys_nxt;
      sel_r    <= sel_nxt;
    end
  end

  assign select_output_word = sel_r;

  // ----------------------------------------------------------------
  // Register read mux
  // ----------------------------------------------------------------
  always_comb
  begin
    case (rb.rd_addr)
      ADDR_CTRL:     rb.rd_data = {31'h0, ctrl_r[CTRL_EN_BIT]};
      ADDR_DATA_LO:  rb.rd_data = {16'h0, digits_r[15:0]};
      ADDR_DATA_HI:  rb.rd_data = {16'h0, digits_r[31:16]};
      ADDR_KEYS:     rb.rd_data = {16'h0, keys_r};
      ADDR_STATUS:   rb.rd_data = {27'h0, sel_r[KEYDOWN_BIT], 2'h0, err, run};
      ADDR_IRQ_STAT: rb.rd_data = {29'h0, ist_r};
      ADDR_IRQ_EN:   rb.rd_data = {29'h0, ien_r};
      ADDR_CFG:      rb.rd_data = cfg_r;
      default:       rb.rd_data = 32'h0;
    endcase
  end

endmodule
`default_nettype wire

// ### verification/hkscn_keypad.sv
// Passive 4 x 4 key matrix model for the scanner bench.
// Assumes a high sense line means a closed switch to a driven select.
`timescale 1ns/1ps
`default_nettype none
module hkscn_keypad
(
  input  wire logic [3:0] sel,
  input  wire logic       dn_a,
  input  wire logic [3:0] key_a,
  input  wire logic       dn_b,
  input  wire logic [3:0] key_b,
  output logic      [3:0] sense
);
  // Key joins column key[1:0] to row key[3:2]; open rows pull low
  always_comb
  begin
    sense = 4'h0;
    if (dn_a && sel[key_a[1:0]]) sense[key_a[3:2]] = 1'b1;
    if (dn_b && sel[key_b[1:0]]) sense[key_b[3:2]] = 1'b1;
  end
endmodule
`default_nettype wire

// ### verification/hkscn_checker.sv
// Port checks of the keypad scanner.
// Assumes a bind to hkscn_top; one clock, hresetn async active low.
`timescale 1ns/1ps
`default_nettype none
module hkscn_checker
  import hkscn_pkg::*;
#(
  parameter int unsigned SCAN_TICKS = hkscn_pkg::SCAN_TICKS_DEF
)
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hwdata,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic        hresp,
  input wire logic [3:0]  sense_input_word,
  input wire logic [4:0]  select_output_word
);
  logic       ctl_wr_r;
  logic       en_r;
  logic [7:0] age_r;

  // Follows the run bit from bus writes, counts cycles since reset
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctl_wr_r <= 1'b0;
      en_r     <= 1'b1;
      age_r    <= 8'h0;
    end
    else
    begin
      ctl_wr_r <= hsel && htrans[1] && hready && hwrite && haddr[5:0] == ADDR_CTRL;
      if (ctl_wr_r) en_r <= hwdata[CTRL_EN_BIT];
      if (age_r != 8'hff) age_r <= age_r + 8'h1;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Two cycles with the run bit off
  sequence s_stopped;
    !en_r [*2];
  endsequence

  // Select moves from one plain column drive to another
  sequence s_stepping;
    $changed(select_output_word) && select_output_word != 5'h0
      && $past(select_output_word) != 5'h0 && !select_output_word[4]
      && !$past(select_output_word[4]);
  endsequence

  // Key-down seen on two samples in a row
  sequence s_held;
    select_output_word[4] ##1 select_output_word[4];
  endsequence

  a_one_select: assert property ($onehot0(select_output_word[3:0]))
    else $error("several select lines high");
  a_ahb_okay: assert property (hreadyout && !hresp)
    else $error("wait state or error response");
  a_hrdata_idle: assert property (!(hsel && htrans[1] && hready) |=> hrdata == 32'h0)
    else $error("read data outside data phase");
  a_keydown_col: assert property (select_output_word[4] |->
    $onehot(select_output_word[3:0]))
    else $error("key down without its column");
  a_sel_advance: assert property (s_stepping |->
    select_output_word[3:0] == {$past(select_output_word[2:0]), $past(select_output_word[3])})
    else $error("select did not step to next line");
  a_accept_cause: assert property ($rose(select_output_word[4]) |->
    $past(|sense_input_word, 3))
    else $error("key down without a sensed row");
  a_held_stable: assert property (s_held |-> $stable(select_output_word))
    else $error("select moved while key held");
  a_stop_quiet: assert property (s_stopped |-> select_output_word == 5'h0)
    else $error("select driven while stopped");
  a_start_scan: assert property (age_r == SCAN_TICKS + 2 |->
    select_output_word == 5'h01)
    else $error("first scan tick missing");
endmodule
bind hkscn_top hkscn_checker #(.SCAN_TICKS(SCAN_TICKS)) hkscn_checker_inst (.hclk, .hresetn,
  .hsel, .haddr, .htrans, .hwrite, .hready, .hwdata, .hreadyout, .hrdata, .hresp,
  .sense_input_word, .select_output_word);
`default_nettype wire

// ### verification/testbench.sv
// Self-checking bench: AHB-Lite master tasks and a key matrix model.
// Assumes hkscn_top, hkscn_keypad and the bound checker compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp, msg) begin tests_run++; if ((got) !== (exp)) begin miscompares++; \
  $display("CHECK FAILED %0t %s", $time, msg); end end
module testbench;
  import hkscn_pkg::*;
  localparam int unsigned ST = 4;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        hresp;
  logic [3:0]  sense;
  logic [4:0]  sel;
  logic        irq;
  logic        dn_a;
  logic        dn_b;
  logic [3:0]  key_a;
  logic [31:0] exp_dig;
  logic [31:0] rd;
  int          miscompares;
  int          tests_run;
  int          waited;
  logic [31:0] cfg_tab [6] = '{32'h12, 32'h00a0_0100, 32'h6142_0100, 32'h6141_0100, 32'h33, 32'h0};
  logic        err_tab [6] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};

  hkscn_top #(.SCAN_TICKS(ST), .CONFIRM(CONFIRM_DEF)) hkscn_top_inst (.hclk, .hresetn, .hsel,
    .haddr, .htrans, .hwrite, .hsize(3'h2), .hready(hreadyout), .hwdata, .hreadyout, .hrdata,
    .hresp, .sense_input_word(sense), .select_output_word(sel), .irq);
  hkscn_keypad hkscn_keypad_inst (.sel, .dn_a, .key_a, .dn_b, .key_b(key_a ^ 4'h4), .sense);

  // 100 MHz clock
  initial
  begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  // Verdict and end of run
  task automatic end_of_test;
    if (miscompares == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Waits for hready high at a rising edge, taking read data at that edge
  task automatic wait_rdy(output logic [31:0] d);
    d = 32'h0;
    for (int n = 0; n < 50; n++)
    begin
      @(posedge hclk);
      if (hreadyout === 1'b1)
      begin
        d = hrdata;
        return;
      end
    end
    miscompares++;
    end_of_test;
  endtask

  // One single word transfer, entered just after a rising edge
  task automatic xfer(input logic w, input logic [5:0] a, input logic [31:0] wd);
    logic [31:0] dummy;
    hsel   <= 1'b1;
    haddr  <= {26'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    wait_rdy(dummy);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy(rd);
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] v);
    xfer(1'b1, a, v);
  endtask

  task automatic chk_rd(input logic [5:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    `CHK(rd, e, "register read")
  endtask

  // Waits for the key-down line to reach v, counting cycles
  task automatic wait_kd(input logic v);
    waited = 0;
    while (sel[4] !== v)
    begin
      @(posedge hclk);
      waited++;
      if (waited > 40 * ST)
      begin
        miscompares++;
        end_of_test;
      end
    end
  endtask

  // Expected digit register after one accepted key
  function automatic logic [31:0] shift_in(logic [31:0] d, logic [3:0] k);
    return {d[27:0], k};
  endfunction

  // Main sequence
  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    dn_a = 1'b0;
    dn_b = 1'b0;
    key_a = 4'h0;
    miscompares = 0;
    tests_run = 0;
    exp_dig = 32'h0;
    void'($urandom(32'h74dd));
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk_rd(ADDR_STATUS, 32'h1);
    chk_rd(ADDR_KEYS, 32'h0);
    chk_rd(6'h24, 32'h0);
    chk_rd(ADDR_IRQ_EN, 32'h0);
    wr(ADDR_IRQ_EN, 32'h7);
    // Corner keys 0 and f, then random keys past eight digits
    for (int i = 0; i < 12; i++)
    begin
      key_a <= (i == 0) ? 4'h0 : (i == 1) ? 4'hf : 4'($urandom_range(15));
      dn_a  <= 1'b1;
      wait_kd(1'b1);
      `CHK(waited >= 2 * ST && waited <= 14 * ST, 1'b1, "key latency")
      exp_dig = shift_in(exp_dig, key_a);
      dn_b <= 1'b1;
      repeat (3 * ST) @(posedge hclk);
      chk_rd(ADDR_KEYS, 32'h1 << key_a);
      chk_rd(ADDR_STATUS, 32'h11);
      `CHK(irq, 1'b1, "irq on key")
      dn_a <= 1'b0;
      dn_b <= 1'b0;
      wait_kd(1'b0);
      chk_rd(ADDR_KEYS, 32'h0);
      chk_rd(ADDR_DATA_LO, {16'h0, exp_dig[15:0]});
      chk_rd(ADDR_DATA_HI, {16'h0, exp_dig[31:16]});
      chk_rd(ADDR_IRQ_STAT, 32'h3);
      wr(ADDR_IRQ_CLR, 32'h7);
      repeat (2) @(posedge hclk);
      `CHK(irq, 1'b0, "irq after clear")
    end
    // Stopped scanner keeps its registers and drives nothing
    wr(ADDR_CTRL, 32'h0);
    key_a <= 4'h5;
    dn_a  <= 1'b1;
    repeat (20 * ST) @(posedge hclk);
    `CHK(sel, 5'h0, "select while stopped")
    chk_rd(ADDR_KEYS, 32'h0);
    chk_rd(ADDR_DATA_LO, {16'h0, exp_dig[15:0]});
    chk_rd(ADDR_STATUS, 32'h0);
    wr(ADDR_CTRL, 32'h1);
    wait_kd(1'b1);
    exp_dig = shift_in(exp_dig, 4'h5);
    dn_a <= 1'b0;
    wait_kd(1'b0);
    chk_rd(ADDR_DATA_LO, {16'h0, exp_dig[15:0]});
    // Area and indirect address settings
    wr(ADDR_IRQ_CLR, 32'h7);
    foreach (cfg_tab[i])
    begin
      wr(ADDR_CFG, cfg_tab[i]);
      chk_rd(ADDR_STATUS, {30'h0, err_tab[i], 1'b1});
    end
    chk_rd(ADDR_IRQ_STAT, 32'h4);
    // Clear command empties the digit register while scanning stays on
    wr(ADDR_CTRL, 32'h3);
    chk_rd(ADDR_DATA_LO, 32'h0);
    chk_rd(ADDR_DATA_HI, 32'h0);
    chk_rd(ADDR_STATUS, 32'h1);
    end_of_test;
  end
endmodule
`default_nettype wire
